// ### logic/pti_pkg.sv
// constants for the timer and serial port pin block
package pti_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_TMR_DATA = 6'h00;
   localparam logic [5:0] IDX_TMR_READBACK = 6'h01;
   localparam logic [5:0] IDX_TMR_DIR = 6'h02;
   localparam logic [5:0] IDX_TMR_DRIVE = 6'h03;
   localparam logic [5:0] IDX_TMR_PULL_EN = 6'h04;
   localparam logic [5:0] IDX_TMR_PULL_POL = 6'h05;
   localparam logic [5:0] IDX_SER_DATA = 6'h08;
   localparam logic [5:0] IDX_SER_READBACK = 6'h09;
   localparam logic [5:0] IDX_SER_DIR = 6'h0A;
   localparam logic [5:0] IDX_SER_DRIVE = 6'h0B;
   localparam logic [5:0] IDX_SER_PULL_EN = 6'h0C;
   localparam logic [5:0] IDX_SER_PULL_POL = 6'h0D;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;

   // reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_DRIVE = 8'h00;
   localparam logic [7:0] RST_TMR_PULL_EN = 8'h00;
   localparam logic [7:0] RST_SER_PULL_EN = 8'hFF;
   localparam logic [7:0] RST_PULL_POL = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // timer port implements only the upper nibble
   localparam int TMR_LO = 4;
   localparam logic [7:0] TMR_IMPL_MASK = 8'hF0;

   // event bits of status and mask
   localparam int EV_RO_WRITE = 0;
   localparam int EV_UNMAPPED = 1;
   localparam int EV_OVERRIDE = 2;
   localparam int EV_W = 3;

   // cycles the document allows after a direction change before readback is trustworthy
   localparam int DIR_SETTLE_CYC = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/pti_port_block.sv
// timer and serial shared port pins with an AXI4-Lite register slave
// How it works
// [RQ1] data read gives latched bit where direction is 1, else synced pin level
// [RQ2] readback register always gives synced pin levels; writes to it ignored
// [RQ3] direction bit 1 makes pin output, 0 input, unless peripheral overrides
// [RQ4] after a direction change, reads may be stale up to two bus cycles; here synced pin reads can lag up to five
// [RQ5] reduced-drive bit selects third-strength drive, ignored while pin is input
// [RQ6] pull enable acts only on inputs; timer port pulls reset disabled
// [RQ7] pull select 1 gives pull-down, 0 gives pull-up, when pulling on input
// [RQ8] pull select doubles as edge select only on interrupt-capable ports
// [RQ9] these two ports have no pin interrupt or edge detection
// [RQ10] enabled timer output compare forces its pin output, timer drives it
// [RQ11] disabled compare or input capture leaves direction bit in control
// [RQ12] enabled serial peripheral owns upper four serial pins and their direction
// [RQ13] enabled transmitter forces its pin output, enabled receiver forces input
// [RQ14] disabled serial function returns direction control to direction bits
// [RQ15] read data is sampled on the bus clock and held stable
// [RQ16] serial port pulls reset enabled with pull-up selected
// [RQ17] pin levels are synchronised on the bus clock before any read
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module pti_port_block #(
   parameter int ADDR_W = 8
) (
   input wire logic MCLK,
   input wire logic RESET_N,
   // AXI4-Lite slave
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   output logic IRQ,
   // timer shared pins, upper nibble of the timer port
   input wire logic [3:0] TMR_PIN_IN,
   output logic [3:0] TMR_PIN_OUT,
   output logic [3:0] TMR_PIN_OE_N,
   output logic [3:0] TMR_PIN_REDUCED,
   output logic [3:0] TMR_PIN_PULL_UP,
   output logic [3:0] TMR_PIN_PULL_DOWN,
   output logic [3:0] TMR_PIN_LEVEL,
   input wire logic [3:0] TMR_OC_EN,
   input wire logic [3:0] TMR_OC_DATA,
   // serial shared pins
   input wire logic [7:0] SER_PIN_IN,
   output logic [7:0] SER_PIN_OUT,
   output logic [7:0] SER_PIN_OE_N,
   output logic [7:0] SER_PIN_REDUCED,
   output logic [7:0] SER_PIN_PULL_UP,
   output logic [7:0] SER_PIN_PULL_DOWN,
   output logic [7:0] SER_PIN_LEVEL,
   input wire logic SPI_EN,
   input wire logic [3:0] SPI_DIR,
   input wire logic [3:0] SPI_OUT,
   input wire logic UART_A_TX_EN,
   input wire logic UART_A_TX_DATA,
   input wire logic UART_A_RX_EN,
   input wire logic UART_B_TX_EN,
   input wire logic UART_B_TX_DATA,
   input wire logic UART_B_RX_EN
);

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] tmr_data_reg, tmr_dir_reg, tmr_drive_reg, tmr_pe_reg, tmr_pol_reg;
   logic [7:0] ser_data_reg, ser_dir_reg, ser_drive_reg, ser_pe_reg, ser_pol_reg;
   logic [pti_pkg::EV_W-1:0] status_reg, status_next, mask_reg;
   logic irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three flops, a change counts once stages two and three agree
   logic [11:0] pin_raw;
   logic [11:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
   assign pin_raw = {TMR_PIN_IN, SER_PIN_IN};

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1_reg <= 12'h000;
         sync2_reg <= 12'h000;
         sync3_reg <= 12'h000;
         level_reg <= 12'h000;
      end else begin
         sync1_reg <= pin_raw; // RQ17
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         level_reg <= (sync2_reg & sync3_reg) | (level_reg & (sync2_reg ^ sync3_reg));
      end
   end

   logic [3:0] tmr_lvl;
   logic [7:0] ser_lvl;
   assign tmr_lvl = level_reg[11:8];
   assign ser_lvl = level_reg[7:0];

   ////////////////////////////////////////////////////////////////////////
   // pin direction and drive, peripheral overrides first
   logic [3:0] tmr_out_en, tmr_out_val;
   logic [7:0] ser_out_en, ser_out_val;
   // compare owns the pin; direction bit keeps its latched value unused
   assign tmr_out_en = TMR_OC_EN | tmr_dir_reg; // RQ3 RQ10 RQ11
   assign tmr_out_val = (TMR_OC_EN & TMR_OC_DATA) | (~TMR_OC_EN & tmr_data_reg); // RQ10
   assign ser_out_en[7:4] = SPI_EN ? SPI_DIR : ser_dir_reg[7:4]; // RQ12 RQ14
   assign ser_out_val[7:4] = SPI_EN ? SPI_OUT : ser_data_reg[7:4]; // RQ12
   assign ser_out_en[3] = UART_B_TX_EN | ser_dir_reg[3]; // RQ13 RQ14
   assign ser_out_val[3] = UART_B_TX_EN ? UART_B_TX_DATA : ser_data_reg[3]; // RQ13
   assign ser_out_en[2] = ~UART_B_RX_EN & ser_dir_reg[2]; // RQ13 RQ14
   assign ser_out_val[2] = ser_data_reg[2];
   assign ser_out_en[1] = UART_A_TX_EN | ser_dir_reg[1]; // RQ13 RQ14
   assign ser_out_val[1] = UART_A_TX_EN ? UART_A_TX_DATA : ser_data_reg[1]; // RQ13
   assign ser_out_en[0] = ~UART_A_RX_EN & ser_dir_reg[0]; // RQ3 RQ13
   assign ser_out_val[0] = ser_data_reg[0];

   // pull select only steers the pull here; no edge detector exists on these ports
   logic [3:0] tmr_pu, tmr_pd;
   logic [7:0] ser_pu, ser_pd;
   assign tmr_pu = tmr_pe_reg & ~tmr_out_en & ~tmr_pol_reg; // RQ6 RQ7 RQ8 RQ9
   assign tmr_pd = tmr_pe_reg & ~tmr_out_en & tmr_pol_reg; // RQ6 RQ7
   assign ser_pu = ser_pe_reg & ~ser_out_en & ~ser_pol_reg; // RQ6 RQ7 RQ16
   assign ser_pd = ser_pe_reg & ~ser_out_en & ser_pol_reg; // RQ6 RQ7

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         TMR_PIN_OUT <= 4'h0;
         TMR_PIN_OE_N <= 4'hF;
         TMR_PIN_REDUCED <= 4'h0;
         TMR_PIN_PULL_UP <= 4'h0;
         TMR_PIN_PULL_DOWN <= 4'h0;
         SER_PIN_OUT <= 8'h00;
         SER_PIN_OE_N <= 8'hFF;
         SER_PIN_REDUCED <= 8'h00;
         SER_PIN_PULL_UP <= 8'h00;
         SER_PIN_PULL_DOWN <= 8'h00;
      end else begin
         TMR_PIN_OUT <= tmr_out_val;
         TMR_PIN_OE_N <= ~tmr_out_en;
         TMR_PIN_REDUCED <= tmr_drive_reg & tmr_out_en; // RQ5
         TMR_PIN_PULL_UP <= tmr_pu;
         TMR_PIN_PULL_DOWN <= tmr_pd;
         SER_PIN_OUT <= ser_out_val;
         SER_PIN_OE_N <= ~ser_out_en;
         SER_PIN_REDUCED <= ser_drive_reg & ser_out_en; // RQ5
         SER_PIN_PULL_UP <= ser_pu;
         SER_PIN_PULL_DOWN <= ser_pd;
      end
   end

   assign TMR_PIN_LEVEL = tmr_lvl; // timer monitors the pin, RQ11
   assign SER_PIN_LEVEL = ser_lvl;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   logic aw_rdy_reg, w_rdy_reg, aw_full_reg, w_full_reg, bvalid_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic [1:0] bresp_reg;
   logic aw_take, w_take, do_write, aw_full_next, w_full_next;
   logic [5:0] w_idx;
   logic w_hi_ok, w_map, w_ro, w_en;

   assign aw_take = AWVALID & aw_rdy_reg;
   assign w_take = WVALID & w_rdy_reg;
   assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
   assign w_full_next = (w_full_reg | w_take) & ~do_write;
   assign w_idx = aw_addr_reg[7:2];
   assign w_hi_ok = (aw_addr_reg >> 8) == '0;
   // readback registers are mapped but refuse writes with OKAY and set the refused-write event
   assign w_ro = w_hi_ok && (w_idx == pti_pkg::IDX_TMR_READBACK || w_idx == pti_pkg::IDX_SER_READBACK);
   assign w_map = w_hi_ok && (w_idx <= pti_pkg::IDX_TMR_PULL_POL ||
      (w_idx >= pti_pkg::IDX_SER_DATA && w_idx <= pti_pkg::IDX_SER_PULL_POL) ||
      w_idx == pti_pkg::IDX_IRQ_STATUS || w_idx == pti_pkg::IDX_IRQ_MASK);
   assign w_en = do_write & w_strb_reg & ~w_ro; // RQ2

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         aw_rdy_reg <= 1'b1;
         w_rdy_reg <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= pti_pkg::RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         aw_rdy_reg <= ~aw_full_next;
         w_rdy_reg <= ~w_full_next;
         if (aw_take) begin
            aw_addr_reg <= AWADDR;
         end
         if (w_take) begin
            w_data_reg <= WDATA[7:0];
            w_strb_reg <= WSTRB[0];
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= w_map ? pti_pkg::RESP_OKAY : pti_pkg::RESP_SLVERR;
         end else if (BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         tmr_data_reg <= pti_pkg::RST_DATA[7:4];
         tmr_dir_reg <= pti_pkg::RST_DIR[7:4];
         tmr_drive_reg <= pti_pkg::RST_DRIVE[7:4];
         tmr_pe_reg <= pti_pkg::RST_TMR_PULL_EN[7:4]; // RQ6
         tmr_pol_reg <= pti_pkg::RST_PULL_POL[7:4];
         ser_data_reg <= pti_pkg::RST_DATA;
         ser_dir_reg <= pti_pkg::RST_DIR;
         ser_drive_reg <= pti_pkg::RST_DRIVE;
         ser_pe_reg <= pti_pkg::RST_SER_PULL_EN; // RQ16
         ser_pol_reg <= pti_pkg::RST_PULL_POL; // RQ16
         mask_reg <= pti_pkg::RST_IRQ;
      end else if (w_en && w_hi_ok) begin
         if (w_idx == pti_pkg::IDX_TMR_DATA) begin
            tmr_data_reg <= w_data_reg[7:4];
         end else if (w_idx == pti_pkg::IDX_TMR_DIR) begin
            tmr_dir_reg <= w_data_reg[7:4];
         end else if (w_idx == pti_pkg::IDX_TMR_DRIVE) begin
            tmr_drive_reg <= w_data_reg[7:4];
         end else if (w_idx == pti_pkg::IDX_TMR_PULL_EN) begin
            tmr_pe_reg <= w_data_reg[7:4];
         end else if (w_idx == pti_pkg::IDX_TMR_PULL_POL) begin
            tmr_pol_reg <= w_data_reg[7:4];
         end else if (w_idx == pti_pkg::IDX_SER_DATA) begin
            ser_data_reg <= w_data_reg;
         end else if (w_idx == pti_pkg::IDX_SER_DIR) begin
            ser_dir_reg <= w_data_reg;
         end else if (w_idx == pti_pkg::IDX_SER_DRIVE) begin
            ser_drive_reg <= w_data_reg;
         end else if (w_idx == pti_pkg::IDX_SER_PULL_EN) begin
            ser_pe_reg <= w_data_reg;
         end else if (w_idx == pti_pkg::IDX_SER_PULL_POL) begin
            ser_pol_reg <= w_data_reg;
         end else if (w_idx == pti_pkg::IDX_IRQ_MASK) begin
            mask_reg <= w_data_reg[pti_pkg::EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; data captured at address accept so it holds stable
   logic ar_rdy_reg, rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic ar_take, r_hi_ok, r_map;
   logic [5:0] r_idx;
   logic [7:0] tmr_data_rd, ser_data_rd, rd_byte;

   assign ar_take = ARVALID & ar_rdy_reg;
   assign r_idx = ARADDR[7:2];
   assign r_hi_ok = (ARADDR >> 8) == '0;
   assign tmr_data_rd = {(tmr_dir_reg & tmr_data_reg) | (~tmr_dir_reg & tmr_lvl), 4'h0}; // RQ1
   assign ser_data_rd = (ser_dir_reg & ser_data_reg) | (~ser_dir_reg & ser_lvl); // RQ1 RQ4
   assign r_map = r_hi_ok && (r_idx <= pti_pkg::IDX_TMR_PULL_POL ||
      (r_idx >= pti_pkg::IDX_SER_DATA && r_idx <= pti_pkg::IDX_SER_PULL_POL) ||
      r_idx == pti_pkg::IDX_IRQ_STATUS || r_idx == pti_pkg::IDX_IRQ_MASK);
   assign rd_byte =
      !r_hi_ok ? 8'h00 :
      r_idx == pti_pkg::IDX_TMR_DATA ? tmr_data_rd :
      r_idx == pti_pkg::IDX_TMR_READBACK ? {tmr_lvl, 4'h0} : // RQ2
      r_idx == pti_pkg::IDX_TMR_DIR ? {tmr_dir_reg, 4'h0} :
      r_idx == pti_pkg::IDX_TMR_DRIVE ? {tmr_drive_reg, 4'h0} :
      r_idx == pti_pkg::IDX_TMR_PULL_EN ? {tmr_pe_reg, 4'h0} :
      r_idx == pti_pkg::IDX_TMR_PULL_POL ? {tmr_pol_reg, 4'h0} :
      r_idx == pti_pkg::IDX_SER_DATA ? ser_data_rd :
      r_idx == pti_pkg::IDX_SER_READBACK ? ser_lvl : // RQ2
      r_idx == pti_pkg::IDX_SER_DIR ? ser_dir_reg :
      r_idx == pti_pkg::IDX_SER_DRIVE ? ser_drive_reg :
      r_idx == pti_pkg::IDX_SER_PULL_EN ? ser_pe_reg :
      r_idx == pti_pkg::IDX_SER_PULL_POL ? ser_pol_reg :
      r_idx == pti_pkg::IDX_IRQ_STATUS ? {5'h00, status_reg} :
      r_idx == pti_pkg::IDX_IRQ_MASK ? {5'h00, mask_reg} : 8'h00;

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ar_rdy_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= pti_pkg::RESP_OKAY;
      end else if (ar_take) begin
         ar_rdy_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rd_byte}; // RQ15
         rresp_reg <= r_map ? pti_pkg::RESP_OKAY : pti_pkg::RESP_SLVERR;
      end else if (rvalid_reg && RREADY) begin
         ar_rdy_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // events: refused write, unmapped access, peripheral override change
   logic [8:0] ovr_vec, ovr_prev_reg;
   logic [pti_pkg::EV_W-1:0] ev_set, ev_clr;
   assign ovr_vec = {TMR_OC_EN, SPI_EN, UART_A_TX_EN, UART_A_RX_EN, UART_B_TX_EN, UART_B_RX_EN};
   assign ev_set[pti_pkg::EV_RO_WRITE] = do_write & w_ro;
   assign ev_set[pti_pkg::EV_UNMAPPED] = (do_write & ~w_map) | (ar_take & ~r_map);
   assign ev_set[pti_pkg::EV_OVERRIDE] = ovr_vec != ovr_prev_reg;
   assign ev_clr = (w_en && w_hi_ok && w_idx == pti_pkg::IDX_IRQ_STATUS) ?
      w_data_reg[pti_pkg::EV_W-1:0] : '0;
   // a new event beats a clear in the same cycle
   assign status_next = (status_reg & ~ev_clr) | ev_set;

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ovr_prev_reg <= 9'h000;
         status_reg <= pti_pkg::RST_IRQ;
         irq_reg <= 1'b0;
      end else begin
         ovr_prev_reg <= ovr_vec;
         status_reg <= status_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   assign AWREADY = aw_rdy_reg;
   assign WREADY = w_rdy_reg;
   assign BVALID = bvalid_reg;
   assign BRESP = bresp_reg;
   assign ARREADY = ar_rdy_reg;
   assign RVALID = rvalid_reg;
   assign RDATA = rdata_reg;
   assign RRESP = rresp_reg;
   assign IRQ = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   property p_data_read;
      ar_take && r_hi_ok && r_idx == pti_pkg::IDX_SER_DATA
         |=> RVALID && ((RDATA[7:0] ^ $past(ser_data_reg)) & $past(ser_dir_reg)) == 8'h00;
   endproperty
   a_data_read: assert property (p_data_read) else $error("data read not latched value"); // RQ1
   property p_readback;
      ar_take && r_hi_ok && r_idx == pti_pkg::IDX_SER_READBACK |=> RDATA[7:0] == $past(ser_lvl);
   endproperty
   a_readback: assert property (p_readback) else $error("readback not pin level"); // RQ2
   property p_dir_out;
      ser_dir_reg[0] && !UART_A_RX_EN |=> !SER_PIN_OE_N[0];
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("direction bit ignored"); // RQ3
   property p_reduced;
      (TMR_PIN_REDUCED & TMR_PIN_OE_N) == 4'h0 && (SER_PIN_REDUCED & SER_PIN_OE_N) == 8'h00;
   endproperty
   a_reduced: assert property (p_reduced) else $error("reduced drive on input"); // RQ5
   property p_pull_input;
      ((SER_PIN_PULL_UP | SER_PIN_PULL_DOWN) & ~SER_PIN_OE_N) == 8'h00;
   endproperty
   a_pull_input: assert property (p_pull_input) else $error("pull on output"); // RQ6
   property p_pull_pol;
      !TMR_OC_EN[0] && !tmr_dir_reg[0] && tmr_pe_reg[0] |=> TMR_PIN_PULL_DOWN[0] == $past(tmr_pol_reg[0])
         && TMR_PIN_PULL_UP[0] == !$past(tmr_pol_reg[0]);
   endproperty
   a_pull_pol: assert property (p_pull_pol) else $error("pull polarity wrong"); // RQ7
   property p_oc_force;
      TMR_OC_EN[0] |=> !TMR_PIN_OE_N[0] && TMR_PIN_OUT[0] == $past(TMR_OC_DATA[0]);
   endproperty
   a_oc_force: assert property (p_oc_force) else $error("compare did not own pin"); // RQ10
   property p_spi_own;
      SPI_EN |=> SER_PIN_OE_N[7:4] == ~$past(SPI_DIR) && SER_PIN_OUT[7:4] == $past(SPI_OUT);
   endproperty
   a_spi_own: assert property (p_spi_own) else $error("serial peripheral not owning pins"); // RQ12
   property p_uart_rx;
      UART_B_RX_EN |=> SER_PIN_OE_N[2];
   endproperty
   a_uart_rx: assert property (p_uart_rx) else $error("receive pin not input"); // RQ13
   property p_rdata_hold;
      RVALID && !RREADY |=> RVALID && $stable(RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed while held"); // RQ15
   property p_sync;
      $stable(SER_PIN_IN)[*5] |-> SER_PIN_LEVEL == SER_PIN_IN;
   endproperty
   a_sync: assert property (p_sync) else $error("pin level not settled"); // RQ17
   c_read: cover property (ar_take ##1 RVALID && !RREADY ##1 RVALID && RREADY);
   c_write: cover property (do_write ##1 BVALID && BREADY);
   c_spi: cover property (!SPI_EN ##1 SPI_EN ##[1:16] !SPI_EN);
   c_irq: cover property (!IRQ ##1 IRQ);
endmodule

// ### bench/pti_pin_model.sv
// external pin model: resolves drive, outside driver, pulls and float
`timescale 1ns/100ps
module pti_pin_model #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic [W-1:0] oe_n,
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] pull_up,
   input wire logic [W-1:0] pull_down,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin
);
   logic [W-1:0] last_reg = '0;
   always_ff @(posedge clk) begin
      last_reg <= pin;
   end
   // a floating pin toggles so a stale value never reads as valid
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (!oe_n[i]) pin[i] = out[i];
         else if (ext_en[i]) pin[i] = ext_val[i];
         else if (pull_up[i]) pin[i] = 1'b1;
         else if (pull_down[i]) pin[i] = 1'b0;
         else pin[i] = ~last_reg[i];
      end
   end
endmodule

// ### bench/tb.sv
// self-checking bench for the port pin block
`timescale 1ns/100ps
module tb;
   logic MCLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, ARREADY, BVALID, RVALID, IRQ;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB, T_IN, T_OUT, T_OE_N, T_RED, T_PU, T_PD, T_LVL, TMR_OC_EN, TMR_OC_DATA, SPI_DIR, SPI_OUT;
   logic [7:0] S_IN, S_OUT, S_OE_N, S_RED, S_PU, S_PD, S_LVL, s_ext_en, s_ext_val;
   logic [1:0] BRESP, RRESP;
   logic SPI_EN, UA_TE, UA_TD, UA_RE, UB_TE, UB_TD, UB_RE;
   int err_count, checked;
   localparam logic [1:0] OK = pti_pkg::RESP_OKAY;
   localparam logic [1:0] SE = pti_pkg::RESP_SLVERR;

   pti_port_block DUT (.MCLK(MCLK), .RESET_N(RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
      .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
      .RVALID(RVALID), .RREADY(RREADY), .IRQ(IRQ), .TMR_PIN_IN(T_IN), .TMR_PIN_OUT(T_OUT), .TMR_PIN_OE_N(T_OE_N),
      .TMR_PIN_REDUCED(T_RED), .TMR_PIN_PULL_UP(T_PU), .TMR_PIN_PULL_DOWN(T_PD), .TMR_PIN_LEVEL(T_LVL),
      .TMR_OC_EN(TMR_OC_EN), .TMR_OC_DATA(TMR_OC_DATA), .SER_PIN_IN(S_IN), .SER_PIN_OUT(S_OUT),
      .SER_PIN_OE_N(S_OE_N), .SER_PIN_REDUCED(S_RED), .SER_PIN_PULL_UP(S_PU), .SER_PIN_PULL_DOWN(S_PD),
      .SER_PIN_LEVEL(S_LVL), .SPI_EN(SPI_EN), .SPI_DIR(SPI_DIR), .SPI_OUT(SPI_OUT), .UART_A_TX_EN(UA_TE),
      .UART_A_TX_DATA(UA_TD), .UART_A_RX_EN(UA_RE), .UART_B_TX_EN(UB_TE), .UART_B_TX_DATA(UB_TD),
      .UART_B_RX_EN(UB_RE));
   // timer pins have no outside driver: only drive, pulls or the float toggle set them
   pti_pin_model #(.W(4)) tpins (.clk(MCLK), .oe_n(T_OE_N), .out(T_OUT), .pull_up(T_PU), .pull_down(T_PD),
      .ext_en(4'h0), .ext_val(4'h0), .pin(T_IN));
   pti_pin_model #(.W(8)) spins (.clk(MCLK), .oe_n(S_OE_N), .out(S_OUT), .pull_up(S_PU), .pull_down(S_PD),
      .ext_en(s_ext_en), .ext_val(s_ext_val), .pin(S_IN));

   ////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (err_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge MCLK);
   endtask
   task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
      logic a, w;
      @(posedge MCLK);
      a = 0;
      w = 0;
      AWADDR <= {i, 2'h0};
      WDATA <= {24'h0, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do begin
         @(posedge MCLK);
         if (!a && AWREADY === 1'b1) a = 1;
         if (!w && WREADY === 1'b1) w = 1;
         if (a) AWVALID <= 1'b0;
         if (w) WVALID <= 1'b0;
      end while (BVALID !== 1'b1);
      chk(BRESP, er);
      BREADY <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
      logic a;
      @(posedge MCLK);
      a = 0;
      ARADDR <= {i, 2'h0};
      ARVALID <= 1'b1;
      do begin
         @(posedge MCLK);
         if (!a && ARREADY === 1'b1) a = 1;
         if (a) ARVALID <= 1'b0;
      end while (RVALID !== 1'b1);
      // ready one edge late, so the answer must stand while unread
      RREADY <= 1'b1;
      @(posedge MCLK);
      chk(RRESP, er);
      if (er === OK) chk(RDATA, {24'h0, e});
      RREADY <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(pti_pkg::IDX_SER_PULL_EN, 8'hFF, OK);
      rd(pti_pkg::IDX_TMR_PULL_EN, 8'h00, OK);
      chk(S_PU, 8'hFF);
      chk(T_PU | T_PD, 4'h0);
      chk(S_OE_N, 8'hFF);
   endtask
   task automatic t_serial_gpio();
      s_ext_en <= 8'hF0;
      s_ext_val <= 8'h30;
      wr(pti_pkg::IDX_SER_DATA, 8'hA5, OK);
      wr(pti_pkg::IDX_SER_DIR, 8'h0F, OK);
      wr(pti_pkg::IDX_SER_DRIVE, 8'hFF, OK);
      wr(pti_pkg::IDX_SER_PULL_POL, 8'hF0, OK);
      idle(8);
      chk(S_OE_N, 8'hF0);
      chk(S_RED, 8'h0F);
      chk({S_PU, S_PD}, 16'h00F0);
      rd(pti_pkg::IDX_SER_DATA, 8'h35, OK);
      wr(pti_pkg::IDX_SER_READBACK, 8'h00, OK);
      rd(pti_pkg::IDX_SER_READBACK, 8'h35, OK);
      chk(S_LVL, 8'h35);
   endtask
   task automatic t_timer();
      wr(pti_pkg::IDX_TMR_PULL_EN, 8'hF0, OK);
      wr(pti_pkg::IDX_TMR_PULL_POL, 8'h30, OK);
      idle(8);
      chk({T_PU, T_PD}, 8'hC3);
      rd(pti_pkg::IDX_TMR_READBACK, 8'hC0, OK);
      wr(pti_pkg::IDX_TMR_DIR, 8'h50, OK);
      wr(pti_pkg::IDX_TMR_DRIVE, 8'hF0, OK);
      TMR_OC_EN <= 4'h3;
      TMR_OC_DATA <= 4'hF;
      idle(8);
      chk(T_OE_N, 4'h8);
      chk(T_OUT[1:0], 2'h3);
      chk(T_RED, 4'h7);
      chk({T_PU, T_PD}, 8'h80);
      rd(pti_pkg::IDX_TMR_DIR, 8'h50, OK);
      // latched zero on bits 6 and 4 differs from the pin on bit 4
      rd(pti_pkg::IDX_TMR_DATA, 8'hA0, OK);
      rd(pti_pkg::IDX_TMR_READBACK, 8'hB0, OK);
      chk(T_LVL, 4'hB);
      TMR_OC_EN <= 4'h0;
      idle(8);
      chk(T_OE_N, 4'hA);
   endtask
   task automatic t_serial_ovr();
      wr(pti_pkg::IDX_SER_DIR, 8'h05, OK);
      {SPI_EN, UA_TE, UA_RE, UB_TE, UB_RE} <= 5'h1F;
      SPI_DIR <= 4'h3;
      SPI_OUT <= 4'h2;
      UA_TD <= 1'b1;
      UB_TD <= 1'b0;
      idle(8);
      chk(S_OE_N, 8'hC5);
      chk({S_OUT[5:4], S_OUT[3], S_OUT[1]}, 4'h9);
      {SPI_EN, UA_TE, UA_RE, UB_TE, UB_RE} <= 5'h00;
      idle(8);
      chk(S_OE_N, 8'hFA);
   endtask
   task automatic t_irq();
      rd(6'h06, 8'h00, SE);
      wr(6'h07, 8'h00, SE);
      rd(pti_pkg::IDX_IRQ_STATUS, 8'h07, OK);
      chk(IRQ, 1'b0);
      wr(pti_pkg::IDX_IRQ_MASK, 8'h02, OK);
      idle(3);
      chk(IRQ, 1'b1);
      wr(pti_pkg::IDX_IRQ_STATUS, 8'h02, OK);
      rd(pti_pkg::IDX_IRQ_STATUS, 8'h05, OK);
      chk(IRQ, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      MCLK = 1'b0;
      forever #2 MCLK = ~MCLK;
   end
   initial begin
      #40000;
      err_count++;
      conclude();
   end
   initial begin
      err_count = 0;
      checked = 0;
      RESET_N = 1'b0;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hF;
      {TMR_OC_EN, TMR_OC_DATA, SPI_DIR, SPI_OUT, s_ext_en, s_ext_val} = '0;
      {SPI_EN, UA_TE, UA_TD, UA_RE, UB_TE, UB_TD, UB_RE} = 7'h00;
      idle(8);
      RESET_N <= 1'b1;
      idle(2);
      t_reset();
      t_serial_gpio();
      t_timer();
      t_serial_ovr();
      t_irq();
      conclude();
   end
endmodule
